//--- emp_cycle_timer.sv
// Machine cycle phase counter, twelve oscillator periods per cycle
`timescale 1ns/1ps
`include "emp_defines.svh"
module emp_cycle_timer (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // Control
  input wire logic restart,
  // Phase
  output logic [3:0] phase_q
);

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      phase_q <= 4'h0;
    end else if (restart || phase_q == `EMP_PH_LAST) begin
      phase_q <= 4'h0;
    end else begin
      phase_q <= phase_q + 4'h1;
    end
  end

endmodule

//--- emp_defines.svh
// Register offsets, field positions, reset values and timing counts
`ifndef EMP_DEFINES_SVH
`define EMP_DEFINES_SVH

// Register offsets on the core register port
`define EMP_OFF_PORT0 8'h80
`define EMP_OFF_AUX 8'h8E
`define EMP_OFF_PORT1 8'h90
`define EMP_OFF_PORT2 8'hA0
`define EMP_OFF_PORT3 8'hB0

// Reset values
`define EMP_RST_PORT 8'hFF
`define EMP_RST_AUX 8'h00

// Field positions
`define EMP_AUX_SUP_BIT 0
`define EMP_P1_TC_COUNT_BIT 0
`define EMP_P1_TC_TRIG_BIT 1
`define EMP_P3_RXD_BIT 0
`define EMP_P3_TXD_BIT 1
`define EMP_P3_IRQ_A_BIT 2
`define EMP_P3_IRQ_B_BIT 3
`define EMP_P3_TA_BIT 4
`define EMP_P3_TB_BIT 5
`define EMP_P3_WR_BIT 6
`define EMP_P3_RD_BIT 7

// Timing in oscillator periods, reset hold also in machine cycles
`define EMP_OSC_PER_MC 12
`define EMP_RST_HOLD_MC 2
`define EMP_RST_HOLD_CYC (`EMP_RST_HOLD_MC * `EMP_OSC_PER_MC)
`define EMP_PH_LAST 4'hB
`define EMP_PH_READY 4'hA
`define EMP_PH_HALF 4'h6
`define EMP_ALE_END 4'h2
`define EMP_ADDR_END 4'h3
`define EMP_PROGRAM_READ_STROBE_START 4'h3
`define EMP_SAMPLE_SUB 4'h5
`define EMP_STB_START 4'h3
`define EMP_STB_END 4'h9
`define EMP_WDATA_END 4'hA

`endif

//--- emp_mem_model.sv
// Partner model: address latch with external program and data memory
`timescale 1ns/1ps
module emp_mem_model (
  // Clock
  input wire logic core_clk,
  // Bus pins
  input wire logic ale,
  input wire logic [7:0] ad_pin,
  input wire logic [7:0] hi_pin,
  input wire logic wr_n,
  // Model outputs
  output logic [7:0] mdata,
  output logic [15:0] wr_addr,
  output logic [7:0] wr_data
);
  logic [7:0] lo;
  logic wr_prev;
  // Follows the bus while the strobe is high, holds once it falls
  always_ff @(posedge core_clk) if (ale) lo <= ad_pin;
  // Released bus rests on the pullups of bus mode
  assign mdata = (ale || !wr_n) ? 8'hFF : (hi_pin ^ lo ^ 8'h3C);
  always_ff @(posedge core_clk) begin
    wr_prev <= wr_n;
    if (wr_n && !wr_prev) begin
      wr_addr <= {hi_pin, lo};
      wr_data <= ad_pin;
    end
  end
endmodule

//--- emp_pkg.sv
// Types shared by the external memory and port control block
package emp_pkg;

  typedef enum logic [2:0] {
    CYC_IDLE,
    CYC_FETCH,
    CYC_RD,
    CYC_WR
  } emp_cyc_type;

  typedef struct packed {
    logic valid;
    logic external_data_move;
    logic write;
    logic data_pointer;
    logic code_move;
    logic [15:0] addr;
    logic [7:0] wdata;
  } emp_req_type;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } emp_sfr_type;

  typedef struct packed {
    logic rxd;
    logic irq_a;
    logic irq_b;
    logic timer_a;
    logic timer_b;
    logic timer_c_count;
    logic timer_c_trig;
  } emp_alt_in_type;

  typedef struct packed {
    logic txd;
    logic clkout;
    logic clkout_en;
  } emp_alt_out_type;

endpackage

//--- emp_port_ctrl.sv
// Port and external memory bus control: strobes, multiplexed bus, port latches
// Functional notes
// - Reset only after the reset pin stays high two machine cycles.
// - Address latch strobe pulses so a latch captures the low address.
// - Address latch strobe runs freely at one sixth of oscillator rate.
// - One address latch strobe pulse dropped per external data access.
// - Auxiliary register bit 0 disables the free-running strobe.
// - When disabled, strobe only in data or code moves, else weak high.
// - Disable bit ignored while executing from external program memory.
// - Program read strobe pulses twice per machine cycle in external run.
// - Two program read strobes skipped in each external data access.
// - Access select low fetches all code externally, 0000H to FFFFH.
// - Access select high runs code from internal program memory.
// - With lock bit 1, access select latched at reset, later ignored.
// - Port zero is the multiplexed low address and data bus, driven.
// - Port two emits high address for fetches and pointer accesses.
// - Port two keeps its latch value for 8-bit indirect data accesses.
// - Port zero open drain; ones in its latch release the pins.
// - Ports one to three pull high for ones and read as inputs.
// - Port one bits 0 and 1 serve timer C count, clock out, trigger.
// - Port three carries serial, interrupt, timer and data strobe pins.
// - One machine cycle is twelve oscillator periods.
`timescale 1ns/1ps
`include "emp_defines.svh"
module emp_port_ctrl
  import emp_pkg::*;
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic resetn,
  // Reset pin, access strap and lock fuse
  input wire logic rst_pin,
  input wire logic external_access_select_n,
  input wire logic lock_bit1,
  // Core register port
  input wire emp_sfr_type sfr,
  output logic [7:0] sfr_rdata_q,
  // Core bus requests and answers
  input wire emp_req_type req,
  output logic req_ready_q,
  output logic [7:0] rdata_q,
  output logic rdata_valid_q,
  output logic device_reset_q,
  output logic ext_exec_q,
  // Alternate pin functions
  input wire emp_alt_out_type alt_out,
  output emp_alt_in_type alt_in_q,
  // Bus strobes
  output logic ale_q,
  output logic ale_oe_q,
  output logic program_read_strobe_n_q,
  // Port zero
  input wire logic [7:0] port_zero_in,
  output logic [7:0] port_zero_out_q,
  output logic [7:0] port_zero_oe_q,
  // Port one
  input wire logic [7:0] port_one_in,
  output logic [7:0] port_one_out_q,
  output logic [7:0] port_one_oe_q,
  // Port two
  input wire logic [7:0] port_two_in,
  output logic [7:0] port_two_out_q,
  output logic [7:0] port_two_oe_q,
  // Port three
  input wire logic [7:0] port_three_in,
  output logic [7:0] port_three_out_q,
  output logic [7:0] port_three_oe_q
);

  localparam logic [4:0] RST_LAST = 5'(`EMP_RST_HOLD_CYC - 1);

  logic [1:0] rst_sync_q;
  logic rst_n;
  logic [33:0] pins_s;
  logic rst_s;
  logic ea_n_s;
  logic [7:0] p0_s;
  logic [7:0] p1_s;
  logic [7:0] p2_s;
  logic [7:0] p3_s;
  logic [3:0] phase_q;
  logic [4:0] rst_cnt_q;
  logic [1:0] init_q;
  logic ea_hold_q;
  logic cap_done;
  logic [7:0] p0_q;
  logic [7:0] p1_q;
  logic [7:0] p2_q;
  logic [7:0] p3_q;
  logic [7:0] aux_q;
  emp_cyc_type cur_q;
  logic [15:0] cur_addr_q;
  logic [7:0] cur_wdata_q;
  logic cur_data_pointer_q;
  logic cur_code_q;
  logic [3:0] sp;
  logic external_data_move_w;
  logic program_read_strobe_act;
  logic ale_en;
  logic [15:0] fetch_addr;
  logic ale_d;
  logic program_read_strobe_n_d;
  logic [7:0] p0_out_d;
  logic [7:0] p0_oe_d;
  logic [7:0] p2_out_d;
  logic [7:0] p2_oe_d;
  logic [7:0] p1_out_d;
  logic [7:0] p1_oe_d;
  logic [7:0] p3_out_d;

  // Position inside the current half cycle
  function automatic logic [3:0] sub_phase(input logic [3:0] ph);
    sub_phase = (ph >= `EMP_PH_HALF) ? ph - `EMP_PH_HALF : ph;
  endfunction

  // Inclusive phase window test
  function automatic logic in_win(input logic [3:0] ph, input logic [3:0] lo, input logic [3:0] hi);
    in_win = (ph >= lo) && (ph <= hi);
  endfunction

  // ****************************************
  // Reset release and pin synchronisers
  // ****************************************
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      rst_sync_q <= 2'h0;
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_q[1];

  emp_sync #(
    .WIDTH(34)
  ) u_sync (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .din({rst_pin, external_access_select_n, port_zero_in, port_one_in, port_two_in, port_three_in}),
    .dout_q(pins_s)
  );
  assign {rst_s, ea_n_s, p0_s, p1_s, p2_s, p3_s} = pins_s;

  emp_cycle_timer u_tmr (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .restart(device_reset_q),
    .phase_q(phase_q)
  );

  // ****************************************
  // Reset pin filter and access strap
  // ****************************************
  // Shorter pulses on the pin are glitches and must not reset the device
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_cnt_q <= 5'h00;
      device_reset_q <= 1'b0;
    end else if (!rst_s) begin
      rst_cnt_q <= 5'h00;
      device_reset_q <= 1'b0;
    end else begin
      if (rst_cnt_q != RST_LAST) begin
        rst_cnt_q <= rst_cnt_q + 5'h01;
      end
      device_reset_q <= (rst_cnt_q == RST_LAST);
    end
  end

  // Strap is caught once the synchroniser has filled after release
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      init_q <= 2'h0;
    end else if (init_q != 2'h3) begin
      init_q <= init_q + 2'h1;
    end
  end
  assign cap_done = (init_q == 2'h3) && !device_reset_q;

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      ea_hold_q <= 1'b1;
    end else if (!cap_done) begin
      ea_hold_q <= ea_n_s;
    end
  end

  // Low strap means every fetch goes to the external program store
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      ext_exec_q <= 1'b0;
    end else begin
      ext_exec_q <= lock_bit1 ? !ea_hold_q : !ea_n_s;
    end
  end

  // ****************************************
  // Register port
  // ****************************************
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      p0_q <= `EMP_RST_PORT;
      p1_q <= `EMP_RST_PORT;
      p2_q <= `EMP_RST_PORT;
      p3_q <= `EMP_RST_PORT;
      aux_q <= `EMP_RST_AUX;
    end else if (device_reset_q) begin
      p0_q <= `EMP_RST_PORT;
      p1_q <= `EMP_RST_PORT;
      p2_q <= `EMP_RST_PORT;
      p3_q <= `EMP_RST_PORT;
      aux_q <= `EMP_RST_AUX;
    end else if (sfr.wr) begin
      if (sfr.addr == `EMP_OFF_PORT0) begin
        p0_q <= sfr.wdata;
      end else if (sfr.addr == `EMP_OFF_PORT1) begin
        p1_q <= sfr.wdata;
      end else if (sfr.addr == `EMP_OFF_PORT2) begin
        p2_q <= sfr.wdata;
      end else if (sfr.addr == `EMP_OFF_PORT3) begin
        p3_q <= sfr.wdata;
      end else if (sfr.addr == `EMP_OFF_AUX) begin
        aux_q <= sfr.wdata;
      end
    end
  end

  // Port reads return the pin levels, which is how inputs are seen
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      sfr_rdata_q <= 8'h00;
    end else if (sfr.rd) begin
      if (sfr.addr == `EMP_OFF_PORT0) begin
        sfr_rdata_q <= p0_s;
      end else if (sfr.addr == `EMP_OFF_PORT1) begin
        sfr_rdata_q <= p1_s;
      end else if (sfr.addr == `EMP_OFF_PORT2) begin
        sfr_rdata_q <= p2_s;
      end else if (sfr.addr == `EMP_OFF_PORT3) begin
        sfr_rdata_q <= p3_s;
      end else if (sfr.addr == `EMP_OFF_AUX) begin
        sfr_rdata_q <= aux_q;
      end else begin
        sfr_rdata_q <= 8'h00;
      end
    end
  end

  // ****************************************
  // Bus cycle capture
  // ****************************************
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      req_ready_q <= 1'b0;
    end else begin
      req_ready_q <= (phase_q == `EMP_PH_READY) && !device_reset_q;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      cur_q <= CYC_IDLE;
      cur_addr_q <= 16'h0000;
      cur_wdata_q <= 8'h00;
      cur_data_pointer_q <= 1'b0;
      cur_code_q <= 1'b0;
    end else if (device_reset_q) begin
      cur_q <= CYC_IDLE;
    end else if (phase_q == `EMP_PH_LAST) begin
      cur_code_q <= 1'b0;
      cur_q <= CYC_IDLE;
      if (req_ready_q && req.valid) begin
        cur_addr_q <= req.addr;
        cur_wdata_q <= req.wdata;
        cur_data_pointer_q <= req.data_pointer;
        cur_code_q <= req.code_move && !req.external_data_move;
        if (req.external_data_move) begin
          cur_q <= req.write ? CYC_WR : CYC_RD;
        end else if (ext_exec_q || req.code_move) begin
          cur_q <= CYC_FETCH;
        end
      end
    end
  end

  // ****************************************
  // Pin and strobe next values
  // ****************************************
  assign sp = sub_phase(phase_q);
  assign external_data_move_w = (cur_q == CYC_RD) || (cur_q == CYC_WR);
  // Idle cycles still strobe in external run so the rate drops only in data cycles
  assign program_read_strobe_act = (cur_q == CYC_FETCH) || (ext_exec_q && cur_q == CYC_IDLE);
  assign ale_en = !aux_q[`EMP_AUX_SUP_BIT] || ext_exec_q || external_data_move_w || cur_code_q;
  assign fetch_addr = cur_addr_q + {15'h0000, phase_q >= `EMP_PH_HALF};

  always_comb begin
    ale_d = 1'b1;
    program_read_strobe_n_d = 1'b1;
    p0_out_d = 8'h00;
    p0_oe_d = ~p0_q;
    p2_out_d = p2_q;
    p2_oe_d = ~p2_q;
    if (ale_en) begin
      ale_d = (sp < `EMP_ALE_END) && !(external_data_move_w && phase_q >= `EMP_PH_HALF);
    end
    if (program_read_strobe_act) begin
      program_read_strobe_n_d = (sp < `EMP_PROGRAM_READ_STROBE_START);
      // Released as the address latch strobe falls so the synchronised sample sees the code byte
      if (sp < `EMP_ALE_END) begin
        p0_out_d = fetch_addr[7:0];
        p0_oe_d = 8'hFF;
      end else begin
        p0_oe_d = 8'h00;
      end
      p2_out_d = fetch_addr[15:8];
      p2_oe_d = 8'hFF;
    end else if (external_data_move_w) begin
      // Program strobe stays high for the whole data cycle
      if (phase_q < `EMP_ADDR_END) begin
        p0_out_d = cur_addr_q[7:0];
        p0_oe_d = 8'hFF;
      end else if (cur_q == CYC_WR && phase_q <= `EMP_WDATA_END) begin
        p0_out_d = cur_wdata_q;
        p0_oe_d = 8'hFF;
      end else begin
        p0_oe_d = 8'h00;
      end
      if (cur_data_pointer_q) begin
        p2_out_d = cur_addr_q[15:8];
        p2_oe_d = 8'hFF;
      end
    end
  end

  // Quasi-bidirectional ports only drive low, save the clock out on port one bit 0; pullups make the ones
  always_comb begin
    p1_out_d = p1_q;
    p1_oe_d = ~p1_q;
    if (alt_out.clkout_en) begin
      p1_out_d[`EMP_P1_TC_COUNT_BIT] = alt_out.clkout;
      p1_oe_d[`EMP_P1_TC_COUNT_BIT] = 1'b1;
    end
    p3_out_d = p3_q;
    p3_out_d[`EMP_P3_TXD_BIT] = p3_q[`EMP_P3_TXD_BIT] & alt_out.txd;
    if (in_win(phase_q, `EMP_STB_START, `EMP_STB_END)) begin
      p3_out_d[`EMP_P3_RD_BIT] = p3_q[`EMP_P3_RD_BIT] & (cur_q != CYC_RD);
      p3_out_d[`EMP_P3_WR_BIT] = p3_q[`EMP_P3_WR_BIT] & (cur_q != CYC_WR);
    end
  end

  // ****************************************
  // Registered pins and read data
  // ****************************************
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      ale_q <= 1'b1;
      ale_oe_q <= 1'b0;
      program_read_strobe_n_q <= 1'b1;
    end else begin
      ale_q <= ale_d;
      ale_oe_q <= ale_en;
      program_read_strobe_n_q <= program_read_strobe_n_d;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      port_zero_out_q <= 8'h00;
      port_zero_oe_q <= 8'h00;
      port_one_out_q <= `EMP_RST_PORT;
      port_one_oe_q <= 8'h00;
      port_two_out_q <= `EMP_RST_PORT;
      port_two_oe_q <= 8'h00;
      port_three_out_q <= `EMP_RST_PORT;
      port_three_oe_q <= 8'h00;
    end else begin
      port_zero_out_q <= p0_out_d;
      port_zero_oe_q <= p0_oe_d;
      port_one_out_q <= p1_out_d;
      port_one_oe_q <= p1_oe_d;
      port_two_out_q <= p2_out_d;
      port_two_oe_q <= p2_oe_d;
      port_three_out_q <= p3_out_d;
      port_three_oe_q <= ~p3_out_d;
    end
  end

  // Read data is taken from the synchronised port zero at strobe end
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_q <= 8'h00;
      rdata_valid_q <= 1'b0;
    end else begin
      rdata_valid_q <= 1'b0;
      if ((cur_q == CYC_FETCH && sp == `EMP_SAMPLE_SUB) || (cur_q == CYC_RD && phase_q == `EMP_STB_END)) begin
        rdata_q <= p0_s;
        rdata_valid_q <= 1'b1;
      end
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      alt_in_q <= '0;
    end else begin
      alt_in_q.rxd <= p3_s[`EMP_P3_RXD_BIT];
      alt_in_q.irq_a <= p3_s[`EMP_P3_IRQ_A_BIT];
      alt_in_q.irq_b <= p3_s[`EMP_P3_IRQ_B_BIT];
      alt_in_q.timer_a <= p3_s[`EMP_P3_TA_BIT];
      alt_in_q.timer_b <= p3_s[`EMP_P3_TB_BIT];
      alt_in_q.timer_c_count <= p1_s[`EMP_P1_TC_COUNT_BIT];
      alt_in_q.timer_c_trig <= p1_s[`EMP_P1_TC_TRIG_BIT];
    end
  end

  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rst_n);

  AST_ALE_FREE: assert property (phase_q == 4'h1 && $past(ale_en) |-> ale_q && ale_oe_q)
    else $error("strobe missing at cycle start");
  AST_ALE_RATE: assert property (phase_q == 4'h1 && $past(ale_en) && !external_data_move_w && !device_reset_q
    |-> ##2 !ale_q ##4 ale_q)
    else $error("strobe not at one sixth rate");
  AST_ALE_SKIP: assert property (phase_q == 4'h7 && external_data_move_w |-> !ale_q)
    else $error("strobe not skipped in data access");
  AST_ALE_SUP: assert property (phase_q == 4'h3 && $past(!ale_en) |-> ale_q && !ale_oe_q)
    else $error("suppressed strobe not weak high");
  AST_SUP_EXT: assert property (phase_q == 4'h1 && ext_exec_q && $past(ext_exec_q) |-> ale_q)
    else $error("strobe stopped in external run");
  AST_PROGRAM_READ_STROBE_TWICE: assert property (phase_q == 4'h4 && cur_q == CYC_FETCH
    |-> !program_read_strobe_n_q ##6 !program_read_strobe_n_q)
    else $error("program strobe not twice per cycle");
  AST_PROGRAM_READ_STROBE_SKIP: assert property (phase_q > 4'h0 && external_data_move_w |-> program_read_strobe_n_q)
    else $error("program strobe in data access");
  AST_P2_LATCH: assert property (phase_q == 4'h5 && external_data_move_w && !cur_data_pointer_q
    |-> port_two_out_q == $past(p2_q))
    else $error("port two not latch value");
  AST_P2_ADDR: assert property (phase_q == 4'h5 && external_data_move_w && cur_data_pointer_q
    |-> port_two_out_q == cur_addr_q[15:8] && port_two_oe_q == 8'hFF)
    else $error("port two not high address");
  AST_P0_OD: assert property (phase_q == 4'h5 && cur_q == CYC_IDLE && !ext_exec_q
    |-> port_zero_oe_q == ~$past(p0_q) && port_zero_out_q == 8'h00)
    else $error("port zero not open drain");
  AST_RST_HOLD: assert property ($rose(device_reset_q) |-> $past(rst_cnt_q) == RST_LAST && $past(rst_s))
    else $error("reset without full hold");
  AST_EA_LATCH: assert property (lock_bit1 && $past(lock_bit1) && cap_done && $past(cap_done, 2)
    |-> $stable(ext_exec_q))
    else $error("latched strap changed");
  AST_AUX_CLR: assert property (device_reset_q |=> !aux_q[`EMP_AUX_SUP_BIT])
    else $error("disable bit survived reset");

  COV_FETCH: cover property (cur_q == CYC_FETCH && rdata_valid_q);
  COV_WRITE: cover property (cur_q == CYC_WR && phase_q == 4'h5);
  COV_READ: cover property (cur_q == CYC_RD && rdata_valid_q);
  COV_SUP: cover property (!ale_oe_q && phase_q == 4'h3);
  COV_RESET: cover property ($rose(device_reset_q));

endmodule

//--- emp_sync.sv
// Two-flop synchroniser for pin inputs
`timescale 1ns/1ps
module emp_sync #(
  parameter int WIDTH = 1
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // Data
  input wire logic [WIDTH-1:0] din,
  output logic [WIDTH-1:0] dout_q
);

  logic [WIDTH-1:0] meta_q;

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_q <= '0;
      dout_q <= '0;
    end else begin
      meta_q <= din;
      dout_q <= meta_q;
    end
  end

endmodule

//--- tb_external_memory_port_control.sv
// Testbench for the external memory and port control block
`timescale 1ns/1ps
module tb_external_memory_port_control;
  import emp_pkg::*;
  logic core_clk = 1'b0;
  logic resetn = 1'b0;
  logic rst_pin = 1'b0;
  logic ea_n = 1'b1;
  logic lock_bit1 = 1'b0;
  emp_alt_out_type alt_out = 3'b100;
  emp_alt_in_type alt_in;
  emp_sfr_type sfr = '0;
  emp_req_type req = '0;
  logic [7:0] sfr_rdata_q, rdata_q, mdata, wr_data;
  logic [7:0] p0o, p0e, p1o, p1e, p2o, p2e, p3o, p3e, p0, p1, p2, p3;
  logic req_ready_q, rdata_valid_q, device_reset_q, ext_exec_q;
  logic ale_q, ale_oe_q, stb_n, ale_prev, stb_prev;
  logic [15:0] wr_addr;
  int bad_count = 0;
  int total_checks = 0;
  int ale_cnt = 0;
  int stb_cnt = 0;

  always #12.5 core_clk = ~core_clk;
  // Released bits rest on their pullups; released port zero bits take the memory model data
  assign p1 = (p1o & p1e) | ~p1e;
  assign p2 = (p2o & p2e) | ~p2e;
  assign p3 = (p3o & p3e) | ~p3e;
  assign p0 = (p0o & p0e) | (mdata & ~p0e);

  emp_port_ctrl dut (.core_clk(core_clk), .resetn(resetn), .rst_pin(rst_pin),
    .external_access_select_n(ea_n), .lock_bit1(lock_bit1), .sfr(sfr), .sfr_rdata_q(sfr_rdata_q),
    .req(req), .req_ready_q(req_ready_q), .rdata_q(rdata_q), .rdata_valid_q(rdata_valid_q),
    .device_reset_q(device_reset_q), .ext_exec_q(ext_exec_q), .alt_out(alt_out), .alt_in_q(alt_in),
    .ale_q(ale_q), .ale_oe_q(ale_oe_q), .program_read_strobe_n_q(stb_n),
    .port_zero_in(p0), .port_zero_out_q(p0o), .port_zero_oe_q(p0e),
    .port_one_in(p1), .port_one_out_q(p1o), .port_one_oe_q(p1e),
    .port_two_in(p2), .port_two_out_q(p2o), .port_two_oe_q(p2e),
    .port_three_in(p3), .port_three_out_q(p3o), .port_three_oe_q(p3e));

  emp_mem_model mem (.core_clk(core_clk), .ale(ale_q), .ad_pin(p0), .hi_pin(p2), .wr_n(p3[6]),
    .mdata(mdata), .wr_addr(wr_addr), .wr_data(wr_data));

  // ****************************************
  // Strobe counters and shared tasks
  // ****************************************
  always @(posedge core_clk) begin
    ale_prev <= ale_q;
    stb_prev <= stb_n;
    if (ale_q && !ale_prev && ale_oe_q) ale_cnt <= ale_cnt + 1;
    if (!stb_n && stb_prev) stb_cnt <= stb_cnt + 1;
  end

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic summarize;
    $display("checks=%0d mismatches=%0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk);
    sfr <= '{1'b1, 1'b0, a, d};
    @(posedge core_clk);
    sfr <= '0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge core_clk);
    sfr <= '{1'b0, 1'b1, a, 8'h00};
    @(posedge core_clk);
    sfr <= '0;
    @(negedge core_clk);
    chk(16'(sfr_rdata_q), 16'(e));
  endtask

  // Counts strobes over the machine cycle that the request starts
  task automatic bus(input emp_req_type r, input int nb, input logic [7:0] e0, input logic [7:0] e1,
                     input int nal, input int nst);
    int a0, s0, n, k;
    logic [7:0] got [2];
    n = 0;
    k = 0;
    @(posedge core_clk);
    req <= r;
    do begin
      @(negedge core_clk);
      n++;
    end while (req_ready_q !== 1'b1 && n < 40);
    @(posedge core_clk);
    req <= '0;
    @(negedge core_clk);
    a0 = ale_cnt;
    s0 = stb_cnt;
    repeat (12) begin
      @(negedge core_clk);
      if (rdata_valid_q === 1'b1 && k < 2) begin
        got[k] = rdata_q;
        k++;
      end
    end
    chk(16'(k), 16'(nb));
    chk(16'(ale_cnt - a0), 16'(nal));
    chk(16'(stb_cnt - s0), 16'(nst));
    if (nb > 0) chk(16'(got[0]), 16'(e0));
    if (nb > 1) chk(16'(got[1]), 16'(e1));
  endtask

  task automatic wait_exec(input logic v);
    int n;
    n = 0;
    while (ext_exec_q !== v && n < 100) begin
      @(negedge core_clk);
      n++;
    end
    chk(16'(ext_exec_q), 16'(v));
  endtask

  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_regs;
    int a0;
    rd(8'h90, 8'hFF);
    rd(8'hA0, 8'hFF);
    rd(8'hB0, 8'hFF);
    chk(16'(alt_in), 16'h007F);
    rd(8'h8E, 8'h00);
    rd(8'h81, 8'h00);
    wr(8'h90, 8'h5A);
    repeat (4) @(posedge core_clk);
    rd(8'h90, 8'h5A);
    chk(16'(p1e), 16'h00A5);
    chk(16'(alt_in), 16'h007D);
    wr(8'h90, 8'hFF);
    wr(8'h8E, 8'h01);
    rd(8'h8E, 8'h01);
    repeat (12) @(negedge core_clk);
    a0 = ale_cnt;
    repeat (24) @(negedge core_clk);
    chk(16'(ale_cnt - a0), 16'h0000);
    chk({ale_q, ale_oe_q}, 16'h0002);
    wr(8'h8E, 8'h00);
    repeat (12) @(negedge core_clk);
    a0 = ale_cnt;
    repeat (24) @(negedge core_clk);
    chk(16'(ale_cnt - a0), 16'h0004);
    $display("test regs done");
  endtask

  task automatic t_bus;
    @(posedge core_clk);
    ea_n <= 1'b0;
    wait_exec(1'b1);
    wr(8'h8E, 8'h01);
    wr(8'hA0, 8'hC3);
    bus('{1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 16'h12F0, 8'h00}, 2, 8'hDE, 8'hDF, 2, 2);
    bus('{1'b1, 1'b1, 1'b0, 1'b1, 1'b0, 16'hBE21, 8'h00}, 1, 8'hA3, 8'h00, 1, 0);
    bus('{1'b1, 1'b1, 1'b0, 1'b0, 1'b0, 16'h0044, 8'h00}, 1, 8'hBB, 8'h00, 1, 0);
    bus('{1'b1, 1'b1, 1'b1, 1'b0, 1'b0, 16'h0077, 8'hA5}, 0, 8'h00, 8'h00, 1, 0);
    repeat (2) @(negedge core_clk);
    chk(wr_addr, 16'hC377);
    chk(16'(wr_data), 16'h00A5);
    @(posedge core_clk);
    ea_n <= 1'b1;
    wait_exec(1'b0);
    $display("test bus done");
  endtask

  task automatic t_rst;
    wr(8'h8E, 8'h01);
    lock_bit1 <= 1'b1;
    wr(8'h90, 8'h00);
    rst_pin <= 1'b1;
    repeat (20) @(negedge core_clk);
    chk(16'(device_reset_q), 16'h0000);
    repeat (10) @(negedge core_clk);
    chk(16'(device_reset_q), 16'h0001);
    @(posedge core_clk);
    rst_pin <= 1'b0;
    repeat (5) @(negedge core_clk);
    chk(16'(device_reset_q), 16'h0000);
    rd(8'h8E, 8'h00);
    rd(8'h90, 8'hFF);
    @(posedge core_clk);
    ea_n <= 1'b0;
    repeat (10) @(negedge core_clk);
    chk(16'(ext_exec_q), 16'h0000);
    @(posedge core_clk);
    ea_n <= 1'b1;
    $display("test reset pin done");
  endtask

  initial begin
    repeat (16) @(posedge core_clk);
    resetn <= 1'b1;
    repeat (20) @(posedge core_clk);
    t_regs;
    t_bus;
    t_rst;
    summarize;
  end

  // Whole run needs well under a thousand cycles
  initial begin
    repeat (20000) @(posedge core_clk);
    bad_count++;
    summarize;
  end
endmodule
